// [cspr_reporter.sv]
`timescale 1ns/1ns
// Contract
// (RL1) Line is two-way: host strobes it, device answers with pulses on it.
// (RL2) Each request gets exactly one reply; its pulse count names one status.
// (RL3) Line is active low, pulled up outside; parties only pull low.
// (RL4) Host keeps its strobe shorter than the device's longest pulse time.
// (RL5) Host strobes low at least 200ns then releases to query.
// (RL6) After the strobe's rising edge, wait the report delay then reply.
// (RL7) Reply pulses are spaced at a fixed pulse period.
// (RL8) Codes: 1 chip hot, 2 battery temp, 3 over-voltage, 23 error.
// (RL9) High setting: 13 precondition through 17 end of charge.
// (RL10) Low setting: 18 precondition through 22 end of charge.
// (RL11) Active over-voltage shutdown is reported through the pulse count.
// (RL12) Battery over-temperature halts charging and is reported as code 2.
// (RL13) Delay, period, low width and strobe limit are parameters.
// (RL14) Code is latched at request end; line ignored until burst ends.
module cspr_reporter #(
	parameter int REPORT_DELAY = cspr_pkg::REPORT_DELAY_CYCLES,
	parameter int PULSE_PERIOD = cspr_pkg::PULSE_PERIOD_CYCLES,
	parameter int PULSE_LOW = cspr_pkg::PULSE_LOW_CYCLES,
	parameter int MAX_STROBE = cspr_pkg::MAX_STROBE_CYCLES
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Status line, open drain.
	input wire logic status_line_in,
	output logic status_line_out,
	output logic status_line_oe_out,
	// Charger conditions.
	input wire logic chip_hot_in,
	input wire logic batt_temp_fault_in,
	input wire logic over_volt_in,
	input wire logic high_rate_setting_in,
	input wire logic [2:0] charge_phase_in,
	// Charge halt on battery temperature fault.
	output logic charge_halt_out
);
	import cspr_pkg::*;

	// Picks the code for the present conditions; faults take priority.
	function automatic logic [4:0] pick_code(input logic hot, input logic bt, input logic ov,
		input logic hi, input logic [2:0] ph);
		logic [4:0] base;
		base = hi ? CODE_HIGH_BASE : CODE_LOW_BASE;
		if (hot) begin
			pick_code = CODE_CHIP_HOT; // [RL8]
		end else if (bt) begin
			pick_code = CODE_BATT_TEMP; // [RL12]
		end else if (ov) begin
			pick_code = CODE_OVER_VOLT; // [RL11]
		end else if (ph <= PHASE_DONE) begin
			pick_code = base + {2'b00, ph}; // [RL9] [RL10]
		end else begin
			pick_code = CODE_REPORT_ERR; // [RL8]
		end
	endfunction

	logic line_sync1;
	logic line_sync2;
	logic line_prev;
	cspr_state_t state;
	cspr_state_t next_state;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic [4:0] code;
	logic [4:0] next_code;
	logic [4:0] sent;
	logic [4:0] next_sent;
	logic drive_low;
	logic next_drive_low;
	logic halt;
	logic next_halt;

	// Two flip-flops guard against a metastable line sample.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_sync1 <= 1'b1;
			line_sync2 <= 1'b1;
			line_prev <= 1'b1;
		end else begin
			line_sync1 <= status_line_in;
			line_sync2 <= line_sync1;
			line_prev <= line_sync2;
		end
	end

	// Sequencer next-state logic. Our own pulses are not mistaken for a strobe
	// because the line is only watched in idle and strobe states.
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_code = code;
		next_sent = sent;
		next_drive_low = 1'b0;
		case (state)
			CSPR_IDLE: begin
				next_timer = '0;
				if (!line_sync2 && line_prev) begin
					next_state = CSPR_STROBE;
				end
			end
			CSPR_STROBE: begin
				next_timer = timer + 1'b1;
				if (line_sync2) begin
					// Rising edge ends the request; latch the code now.
					next_code = pick_code(chip_hot_in, batt_temp_fault_in, over_volt_in,
						high_rate_setting_in, charge_phase_in); // [RL14] [RL2]
					next_timer = '0;
					next_sent = '0;
					next_state = CSPR_WAIT; // [RL6]
				end else if (timer >= TIMER_W'(MAX_STROBE)) begin
					// A stuck-low line is not a request; drop it without a reply.
					next_state = CSPR_IDLE; // [RL4]
				end
			end
			CSPR_WAIT: begin
				next_timer = timer + 1'b1;
				if (timer >= TIMER_W'(REPORT_DELAY - 1)) begin
					next_timer = '0;
					next_state = CSPR_SEND; // [RL6] [RL13]
				end
			end
			CSPR_SEND: begin
				next_timer = timer + 1'b1;
				next_drive_low = (timer < TIMER_W'(PULSE_LOW)); // [RL7] [RL1]
				if (timer >= TIMER_W'(PULSE_PERIOD - 1)) begin
					next_timer = '0;
					next_sent = sent + 1'b1;
					if (sent + 1'b1 >= code) begin
						next_state = CSPR_IDLE; // [RL14]
					end
				end
			end
			default: begin
				next_state = CSPR_IDLE;
			end
		endcase
		next_halt = batt_temp_fault_in; // [RL12]
	end

	// Sequencer registers.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= CSPR_IDLE;
			timer <= '0;
			code <= 5'h00;
			sent <= 5'h00;
			drive_low <= 1'b0;
			halt <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			code <= next_code;
			sent <= next_sent;
			drive_low <= next_drive_low;
			halt <= next_halt;
		end
	end

	// Open drain: data is always low, only the enable moves.
	assign status_line_out = 1'b0; // [RL3]
	assign status_line_oe_out = drive_low; // [RL3]
	assign charge_halt_out = halt;

	sequence s_strobe_end;
		state == CSPR_STROBE && line_sync2;
	endsequence

	property p_wait_after_strobe;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_strobe_end |=> state == CSPR_WAIT && !drive_low;
	endproperty
	a_wait_after_strobe: assert property (p_wait_after_strobe) // [RL6]
		else $error("strobe end did not start report delay");

	property p_no_drive_outside_send;
		@(posedge clk_in) disable iff (!rst_n_in)
		$past(state) != CSPR_SEND |-> !status_line_oe_out;
	endproperty
	a_no_drive_outside_send: assert property (p_no_drive_outside_send) // [RL1]
		else $error("line driven outside reply");

	property p_only_low;
		@(posedge clk_in) disable iff (!rst_n_in)
		status_line_out == 1'b0;
	endproperty
	a_only_low: assert property (p_only_low) // [RL3]
		else $error("line driven high");

	property p_pulse_start;
		@(posedge clk_in) disable iff (!rst_n_in)
		state == CSPR_SEND && timer == '0 |=> status_line_oe_out;
	endproperty
	a_pulse_start: assert property (p_pulse_start) // [RL7]
		else $error("pulse missing at period start");

	property p_pulse_release;
		@(posedge clk_in) disable iff (!rst_n_in)
		state == CSPR_SEND && timer == TIMER_W'(PULSE_LOW) |=> !status_line_oe_out;
	endproperty
	a_pulse_release: assert property (p_pulse_release) // [RL7]
		else $error("pulse low too long");

	property p_code_stable;
		@(posedge clk_in) disable iff (!rst_n_in)
		state == CSPR_SEND |=> $stable(code);
	endproperty
	a_code_stable: assert property (p_code_stable) // [RL14]
		else $error("code changed during reply");

	property p_code_range;
		@(posedge clk_in) disable iff (!rst_n_in)
		state == CSPR_WAIT |-> code >= CODE_CHIP_HOT && code <= CODE_REPORT_ERR
			&& !(code > CODE_OVER_VOLT && code < CODE_HIGH_BASE);
	endproperty
	a_code_range: assert property (p_code_range) // [RL2]
		else $error("unused code latched");

	property p_batt_code;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_strobe_end ##0 (batt_temp_fault_in && !chip_hot_in) |=> code == CODE_BATT_TEMP;
	endproperty
	a_batt_code: assert property (p_batt_code) // [RL12]
		else $error("battery fault not reported");

	property p_ov_code;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_strobe_end ##0 (over_volt_in && !chip_hot_in && !batt_temp_fault_in)
			|=> code == CODE_OVER_VOLT;
	endproperty
	a_ov_code: assert property (p_ov_code) // [RL11]
		else $error("over-voltage not reported");

	property p_halt;
		@(posedge clk_in) disable iff (!rst_n_in)
		batt_temp_fault_in |=> charge_halt_out;
	endproperty
	a_halt: assert property (p_halt) // [RL12]
		else $error("charge not halted on battery fault");
endmodule

// [cspr_pkg.sv]
package cspr_pkg;
	// Status codes carried as pulse counts on the line.
	localparam logic [4:0] CODE_CHIP_HOT = 5'h01;
	localparam logic [4:0] CODE_BATT_TEMP = 5'h02;
	localparam logic [4:0] CODE_OVER_VOLT = 5'h03;
	localparam logic [4:0] CODE_HIGH_BASE = 5'h0D;
	localparam logic [4:0] CODE_LOW_BASE = 5'h12;
	localparam logic [4:0] CODE_REPORT_ERR = 5'h17;
	// Charge phase encoding on the phase input.
	localparam logic [2:0] PHASE_PRECOND = 3'h0;
	localparam logic [2:0] PHASE_REDUCED = 3'h1;
	localparam logic [2:0] PHASE_CC = 3'h2;
	localparam logic [2:0] PHASE_CV = 3'h3;
	localparam logic [2:0] PHASE_DONE = 3'h4;
	// Timing, clock period in ns.
	localparam int CLK_PERIOD_NS = 50;
	localparam int REQUEST_LOW_TIME_NS = 200;
	// Least time rounds up to whole cycles.
	localparam int REQUEST_LOW_CYCLES = (REQUEST_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REPORT_DELAY_NS = 10000;
	localparam int PULSE_PERIOD_NS = 4000;
	localparam int PULSE_LOW_NS = 2000;
	localparam int MAX_STROBE_NS = 100000;
	localparam int REPORT_DELAY_CYCLES = REPORT_DELAY_NS / CLK_PERIOD_NS;
	localparam int PULSE_PERIOD_CYCLES = PULSE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PULSE_LOW_CYCLES = PULSE_LOW_NS / CLK_PERIOD_NS;
	localparam int MAX_STROBE_CYCLES = MAX_STROBE_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 12;
	// Reply sequencer states.
	typedef enum logic [1:0] {
		CSPR_IDLE = 2'b00,
		CSPR_STROBE = 2'b01,
		CSPR_WAIT = 2'b10,
		CSPR_SEND = 2'b11
	} cspr_state_t;
endpackage

// [cspr_host.sv]
`timescale 1ns/1ns
// Host on the far side of the status line: strobes it low, then counts reply pulses.
module cspr_host #(
	parameter int PERIOD = 6,
	parameter int LOW = 3,
	parameter int QUIET = 40
) (
	// Clock.
	input wire logic clk_in,
	// Line level and own pull-down.
	input wire logic line_in,
	output logic line_oe_out,
	// Query control and results.
	input wire logic go_in,
	input wire logic [7:0] strobe_len_in,
	output logic done_out,
	output logic [4:0] count_out,
	output int first_out,
	output logic gap_err_out
);
	int idle;
	int t;
	int last_fall;
	logic prev;
	// A reply is over once the line has stayed high for QUIET cycles.
	initial begin
		line_oe_out = 1'b0;
		done_out = 1'b0;
		count_out = 5'h00;
		first_out = 0;
		gap_err_out = 1'b0;
		forever begin
			@(posedge clk_in iff go_in);
			#1;
			done_out = 1'b0;
			count_out = 5'h00;
			line_oe_out = 1'b1;
			repeat (strobe_len_in) @(posedge clk_in);
			#1;
			line_oe_out = 1'b0;
			t = 0;
			idle = 0;
			prev = 1'b1;
			last_fall = 0;
			// Sample on the falling edge, where the reporter's registered enable has settled.
			while (idle < QUIET) begin
				@(negedge clk_in);
				t++;
				idle = line_in ? idle + 1 : 0;
				if (prev && !line_in) begin
					if (count_out == 5'h00) first_out = t;
					else if (t - last_fall != PERIOD) gap_err_out = 1'b1;
					last_fall = t;
					count_out++;
				end
				if (!prev && line_in && t - last_fall != LOW) gap_err_out = 1'b1;
				prev = line_in;
			end
			done_out = 1'b1;
		end
	end
endmodule

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	import cspr_pkg::*;
	localparam int DLY = 8;
	localparam int PER = 6;
	localparam int LOWC = 3;
	logic clk_in, rst_n_in, hot, bt, ov, hi, dut_oe, dut_d, halt, host_oe, go, done, gerr;
	logic [2:0] ph;
	logic [7:0] slen;
	logic [4:0] cnt;
	int first, seed, n_errors, num_checks, i;
	// Open-drain line with a pull-up: low while either side pulls.
	wire line = ((dut_oe && dut_d === 1'b0) || host_oe) ? 1'b0 : 1'b1;
	cspr_reporter #(.REPORT_DELAY(DLY), .PULSE_PERIOD(PER), .PULSE_LOW(LOWC),
		.MAX_STROBE(40)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.status_line_in(line), .status_line_out(dut_d), .status_line_oe_out(dut_oe),
		.chip_hot_in(hot), .batt_temp_fault_in(bt), .over_volt_in(ov),
		.high_rate_setting_in(hi), .charge_phase_in(ph), .charge_halt_out(halt));
	cspr_host #(.PERIOD(PER), .LOW(LOWC), .QUIET(40)) host (.clk_in(clk_in), .line_in(line),
		.line_oe_out(host_oe), .go_in(go), .strobe_len_in(slen), .done_out(done),
		.count_out(cnt), .first_out(first), .gap_err_out(gerr));
	// Priority: chip heat, battery heat, over-voltage, then phase by setting.
	function automatic logic [4:0] exp_code();
		if (hot) return CODE_CHIP_HOT;
		if (bt) return CODE_BATT_TEMP;
		if (ov) return CODE_OVER_VOLT;
		if (ph > 3'h4) return CODE_REPORT_ERR;
		return (hi ? CODE_HIGH_BASE : CODE_LOW_BASE) + {2'h0, ph};
	endfunction
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic stop_test();
		if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Inputs change during the report delay; the answer must keep the code taken at strobe end.
	task automatic query(input logic [4:0] h_b_o_hi_x, input logic [2:0] p,
		input logic [7:0] len);
		logic [4:0] e;
		int k;
		// Inputs move only just after a rising edge, never in its time step.
		@(posedge clk_in) #2;
		{hot, bt, ov, hi} = h_b_o_hi_x[4:1];
		ph = p;
		slen = len;
		e = (len > 8'd40) ? 5'h00 : exp_code();
		go = 1'b1;
		@(posedge clk_in) #2 go = 1'b0;
		repeat (len + 6) @(posedge clk_in);
		#2 {hot, bt, ov, hi, ph} = 7'($random(seed));
		@(posedge clk_in) #2 chk(halt === bt, "halt");
		for (k = 0; k < 2000 && done !== 1'b1; k++) @(posedge clk_in);
		chk(done === 1'b1, "reply never ended");
		chk(cnt === e, "pulse count");
		chk(e == 0 || (first >= DLY && first <= DLY + 5), "delay");
		chk(gerr === 1'b0 && dut_d === 1'b0, "pulse timing");
	endtask
	// Clock, 50 ns period.
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// Watchdog, well beyond the expected run length.
	initial begin
		#3000000;
		n_errors++;
		stop_test();
	end
	// Phases for both settings, each fault, a refused strobe, then random queries.
	initial begin
		seed = 75;
		{rst_n_in, go, hot, bt, ov, hi, ph, slen} = '0;
		repeat (4) @(posedge clk_in);
		#2 rst_n_in = 1'b1;
		for (i = 0; i < 16; i++) query({3'h0, i[3], 1'b0}, i[2:0], 8'd4 + i[7:0]);
		for (i = 0; i < 4; i++) query({3'h7 >> i, 2'h0}, 3'h2, 8'd10);
		query(5'h00, 3'h1, 8'd60);
		for (i = 0; i < 20; i++) query(5'($random(seed)), 3'($random(seed)), 8'd4 + 8'(i));
		stop_test();
	end
endmodule
